/* include/sep_pkg.sv */
// Package for the serial non-volatile memory command port
package sep_pkg;
    // Organization and geometry
    localparam int SEP_ADDR_W16    = 8;    // Address bits, 16-bit words
    localparam int SEP_ADDR_W8     = 9;    // Address bits, 8-bit words
    localparam int SEP_DATA_W16    = 16;   // Word bits, wide organization
    localparam int SEP_DATA_W8     = 8;    // Word bits, narrow organization
    localparam int SEP_ARRAY_BYTES = 512;  // 4096 bits as bytes
    // Opcodes and sub-commands
    localparam logic [1:0] SEP_OP_EXT   = 2'h0;
    localparam logic [1:0] SEP_OP_WRITE = 2'h1;
    localparam logic [1:0] SEP_OP_READ  = 2'h2;
    localparam logic [1:0] SEP_OP_ERASE = 2'h3;
    localparam logic [1:0] SEP_SUB_LOCK   = 2'h0; // program_lock_cmd
    localparam logic [1:0] SEP_SUB_FILL   = 2'h1; // fill_all_cmd
    localparam logic [1:0] SEP_SUB_CLEAR  = 2'h2; // clear_all_cmd
    localparam logic [1:0] SEP_SUB_UNLOCK = 2'h3;
    // Timing
    localparam int SEP_CLK_MHZ     = 250;
    localparam int SEP_T_WP_MS     = 15;   // Longest program time
    localparam int SEP_T_WP_CYC    = SEP_T_WP_MS * 1000 * SEP_CLK_MHZ;
    localparam int SEP_FIFO_DEPTH  = 32;
    // Pin samples after synchroniser
    typedef struct packed {
        logic sel;
        logic sclk;
        logic sin;
        logic wsel;
    } sep_pins_t;
    // One array write request
    typedef struct packed {
        logic       all;   // Whole array
        logic [8:0] addr;  // Byte address
        logic [15:0] data; // Word, erased value is all ones
        logic       wide;  // 16-bit word
    } sep_wreq_t;
endpackage

/* rtl/sep_core.sv */
// Serial non-volatile memory command port with array and program timer
`timescale 1ns/1ps
module sep_core
    import sep_pkg::*;
#(
    parameter int T_WP_CYC = sep_pkg::SEP_T_WP_CYC
) (
    input  wire logic core_clk,      // System clock
    input  wire logic rst,           // Sync reset
    input  wire logic ce,            // Clock enable
    input  wire logic chip_sel,      // Select pin
    input  wire logic serial_clock,  // Serial clock pin
    input  wire logic serial_in,     // Serial data pin
    input  wire logic width_select,  // Organization pin, pulled up
    output logic      serial_out,    // Serial data out
    output logic      serial_out_oe_n, // Low while driving
    output logic      busy           // Program in progress
);
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01, ST_HDR = 5'h02, ST_DATA = 5'h04, ST_READ = 5'h08, ST_DONE = 5'h10
    } sep_st_t;

    // Two-stage synchroniser for pins
    sep_pins_t s1_r, s2_r, s3_r;
    // Decoder state
    sep_st_t     st_r, st_nxt;
    logic [4:0]  cnt_r, cnt_nxt;
    logic [10:0] hdr_r, hdr_nxt;
    logic [15:0] sh_r, sh_nxt;
    logic        wide_r, wide_nxt;
    logic        pend_r, pend_nxt;     // Command waiting for select fall
    logic [1:0]  pcmd_r, pcmd_nxt;     // 0 unlock,1 lock,2 program
    logic        unl_r, unl_nxt;
    logic        rdy_r, rdy_nxt;       // Ready shown after program
    logic        so_r, so_nxt, oe_n_r, oe_n_nxt;
    sep_wreq_t   wq_r, wq_nxt;
    // Program engine
    logic [$clog2(T_WP_CYC+1)-1:0] tmr_r, tmr_nxt;
    logic        bsy_r, bsy_nxt, push;
    sep_wreq_t   fo;
    logic        fo_v, fo_rdy, f_in_rdy, eng_take;
    logic [7:0]  mem_r [SEP_ARRAY_BYTES];
    logic [8:0]  fill_r, fill_nxt;
    logic [15:0] hold_d_r;
    logic        hold_all_r, hold_wide_r;

    function automatic int unsigned alen(input logic wide);
        alen = wide ? SEP_ADDR_W16 : SEP_ADDR_W8;
    endfunction
    function automatic int unsigned dlen(input logic wide);
        dlen = wide ? SEP_DATA_W16 : SEP_DATA_W8;
    endfunction

    wire sel      = s2_r.sel;
    wire sel_rise = s2_r.sel && !s3_r.sel;
    wire sel_fall = !s2_r.sel && s3_r.sel;
    wire clk_rise = s2_r.sclk && !s3_r.sclk && sel;
    wire din      = s2_r.sin;
    wire [8:0] adr = wide_r ? {hdr_r[7:0], 1'b0} : hdr_r[8:0];
    wire [1:0] op  = wide_r ? hdr_r[9:8] : hdr_r[10:9];
    wire [1:0] sub = wide_r ? hdr_r[7:6] : hdr_r[8:7];

    // Pin synchroniser, third stage only for edge detect
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else if (ce) begin
            s1_r <= '{chip_sel, serial_clock, serial_in, width_select};
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // Command decoder next state
    always_comb begin
        st_nxt   = st_r;
        cnt_nxt  = cnt_r;
        hdr_nxt  = hdr_r;
        sh_nxt   = sh_r;
        wide_nxt = wide_r;
        pend_nxt = pend_r;
        pcmd_nxt = pcmd_r;
        unl_nxt  = unl_r;
        rdy_nxt  = rdy_r;
        so_nxt   = so_r;
        oe_n_nxt = !sel;
        wq_nxt   = wq_r;
        push     = 1'b0;
        if (sel_rise) begin
            st_nxt   = ST_IDLE;
            pend_nxt = 1'b0;
            wide_nxt = s2_r.wsel;
        end else if (sel_fall) begin
            st_nxt = ST_IDLE;
            if (pend_r) begin
                case (pcmd_r)
                    2'h0: unl_nxt = 1'b1;
                    2'h1: unl_nxt = 1'b0;
                    default: push = 1'b1;
                endcase
            end
            pend_nxt = 1'b0;
        end else if (clk_rise) begin
            pend_nxt = 1'b0; // Extra clocks void a pending command
            case (st_r)
                ST_IDLE: begin
                    if (din) begin
                        st_nxt  = ST_HDR;
                        cnt_nxt = 5'(alen(wide_r) + 2);
                        rdy_nxt = 1'b0;
                    end
                end
                ST_HDR: begin
                    hdr_nxt = {hdr_r[9:0], din};
                    cnt_nxt = cnt_r - 5'h1;
                    if (cnt_r == 5'h1) begin
                        st_nxt = ST_DONE;
                        case (wide_r ? hdr_nxt[9:8] : hdr_nxt[10:9])
                            SEP_OP_READ: begin
                                st_nxt  = ST_READ;
                                sh_nxt  = wide_r ?
                                    {mem_r[{hdr_nxt[7:0], 1'b0}], mem_r[{hdr_nxt[7:0], 1'b1}]}
                                    : {mem_r[hdr_nxt[8:0]], 8'h00};
                                cnt_nxt = 5'(dlen(wide_r));
                                so_nxt  = 1'b0;
                            end
                            SEP_OP_WRITE: begin
                                st_nxt  = ST_DATA;
                                cnt_nxt = 5'(dlen(wide_r));
                            end
                            SEP_OP_ERASE: begin
                                pend_nxt = unl_r;
                                pcmd_nxt = 2'h2;
                            end
                            default: begin
                                if ((wide_r ? hdr_nxt[7:6] : hdr_nxt[8:7]) == SEP_SUB_FILL) begin
                                    st_nxt  = ST_DATA;
                                    cnt_nxt = 5'(dlen(wide_r));
                                end else if ((wide_r ? hdr_nxt[7:6] : hdr_nxt[8:7])
                                             == SEP_SUB_UNLOCK) begin
                                    pend_nxt = 1'b1;
                                    pcmd_nxt = 2'h0;
                                end else if ((wide_r ? hdr_nxt[7:6] : hdr_nxt[8:7])
                                             == SEP_SUB_LOCK) begin
                                    pend_nxt = 1'b1;
                                    pcmd_nxt = 2'h1;
                                end else begin
                                    pend_nxt = unl_r;
                                    pcmd_nxt = 2'h2;
                                end
                            end
                        endcase
                    end
                end
                ST_DATA: begin
                    sh_nxt  = {sh_r[14:0], din};
                    cnt_nxt = cnt_r - 5'h1;
                    if (cnt_r == 5'h1) begin
                        st_nxt   = ST_DONE;
                        pend_nxt = unl_r;
                        pcmd_nxt = 2'h2;
                    end
                end
                ST_READ: begin
                    so_nxt = wide_r ? sh_r[15] : sh_r[15];
                    sh_nxt = {sh_r[14:0], 1'b0};
                    if (cnt_r != 5'h0) cnt_nxt = cnt_r - 5'h1;
                    if (cnt_r == 5'h0) so_nxt = 1'b0;
                end
                default: st_nxt = st_r;
            endcase
        end
        if (!bsy_r && bsy_nxt) rdy_nxt = 1'b0;
        if (bsy_r && !bsy_nxt) rdy_nxt = 1'b1; // set wins over a start bit
        // Array write request built from decoded fields
        if (push) begin
            wq_nxt.all  = (op == SEP_OP_EXT);
            wq_nxt.addr = adr;
            wq_nxt.wide = wide_r;
            wq_nxt.data = (op == SEP_OP_ERASE || (op == SEP_OP_EXT && sub == SEP_SUB_CLEAR))
                ? 16'hffff : (wide_r ? sh_r : {sh_r[7:0], 8'h00});
        end
        // Status overrides data while busy or ready pending
        if (sel && (bsy_r || rdy_nxt) && st_r == ST_IDLE) so_nxt = !bsy_r && rdy_nxt;
        // Drive only for status or read data; a start bit releases the pin
        oe_n_nxt = !(sel && (st_nxt == ST_READ
                             || ((bsy_r || rdy_nxt) && st_nxt == ST_IDLE)));
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_r   <= ST_IDLE;
            cnt_r  <= '0;
            hdr_r  <= '0;
            sh_r   <= '0;
            wide_r <= 1'b1;
            pend_r <= 1'b0;
            pcmd_r <= 2'h0;
            unl_r  <= 1'b0;
            rdy_r  <= 1'b0;
            so_r   <= 1'b0;
            oe_n_r <= 1'b1;
            wq_r   <= '0;
        end else if (ce) begin
            st_r   <= st_nxt;
            cnt_r  <= cnt_nxt;
            hdr_r  <= hdr_nxt;
            sh_r   <= sh_nxt;
            wide_r <= wide_nxt;
            pend_r <= pend_nxt;
            pcmd_r <= pcmd_nxt;
            unl_r  <= unl_nxt;
            rdy_r  <= rdy_nxt;
            so_r   <= so_nxt;
            oe_n_r <= oe_n_nxt;
            wq_r   <= wq_nxt;
        end
    end

    // Queue decouples decode from the slow program engine
    logic push_r;
    always_ff @(posedge core_clk) begin
        if (rst) push_r <= 1'b0;
        else if (ce) push_r <= push && f_in_rdy;
    end
    sep_fifo #(.WIDTH($bits(sep_wreq_t)), .DEPTH(SEP_FIFO_DEPTH)) u_fifo (
        .core_clk (core_clk),
        .rst      (rst),
        .ce       (ce),
        .in_valid (push_r),
        .in_ready (f_in_rdy),
        .in_data  (wq_r),
        .out_valid(fo_v),
        .out_ready(fo_rdy),
        .out_data (fo)
    );

    // Program engine: timer, whole-array fill walks one byte per cycle
    assign fo_rdy   = !bsy_r;
    assign eng_take = ce && fo_v && fo_rdy;
    always_comb begin
        bsy_nxt  = bsy_r;
        tmr_nxt  = tmr_r;
        fill_nxt = fill_r;
        if (eng_take) begin
            bsy_nxt  = 1'b1;
            tmr_nxt  = ($clog2(T_WP_CYC+1))'(T_WP_CYC);
            fill_nxt = '0;
        end else if (bsy_r) begin
            if (fill_r != 9'h1ff) fill_nxt = fill_r + 9'h1;
            if (tmr_r > 1) tmr_nxt = tmr_r - 1'b1;
            else if (!hold_all_r || fill_r == 9'h1ff) bsy_nxt = 1'b0; // Walk must reach the end
        end
    end
    always_ff @(posedge core_clk) begin
        if (rst) begin
            bsy_r  <= 1'b0;
            tmr_r  <= '0;
            fill_r <= '0;
        end else if (ce) begin
            bsy_r  <= bsy_nxt;
            tmr_r  <= tmr_nxt;
            fill_r <= fill_nxt;
        end
    end
    // Array storage; whole-array ops hold the head word while busy
    always_ff @(posedge core_clk) begin
        if (ce && eng_take) begin
            hold_d_r    <= fo.data;
            hold_all_r  <= fo.all;
            hold_wide_r <= fo.wide;
            if (!fo.all) begin
                mem_r[fo.addr] <= fo.data[15:8];
                if (fo.wide) mem_r[{fo.addr[8:1], 1'b1}] <= fo.data[7:0];
            end
        end else if (ce && bsy_r && hold_all_r) begin
            mem_r[fill_r] <= (hold_wide_r && fill_r[0]) ? hold_d_r[7:0] : hold_d_r[15:8];
        end
    end

    assign serial_out      = so_r;
    assign serial_out_oe_n = oe_n_r;
    assign busy            = bsy_r;

    // Checks
    a_unsel_hiz: assert property (@(posedge core_clk) disable iff (rst)
        (ce && !s2_r.sel) |=> serial_out_oe_n) else $error("output driven while deselected");
    a_lock_reset: assert property (@(posedge core_clk)
        rst |=> !unl_r) else $error("not locked after reset");
    a_locked_nobusy: assert property (@(posedge core_clk) disable iff (rst)
        (!unl_r && sel_fall) |=> !push_r) else $error("locked command queued");
    a_read_dummy: assert property (@(posedge core_clk) disable iff (rst)
        (ce && st_r == ST_HDR && st_nxt == ST_READ) |=> !so_r) else $error("no dummy zero");
    a_start_hdr: assert property (@(posedge core_clk) disable iff (rst)
        (ce && !sel_rise && !sel_fall && clk_rise && st_r == ST_IDLE && !din) |=> st_r == ST_IDLE)
        else $error("zero began a cycle");
    a_rise_idle: assert property (@(posedge core_clk) disable iff (rst)
        (ce && sel_rise) |=> st_r == ST_IDLE) else $error("select rise kept state");
    a_busy_start: assert property (@(posedge core_clk) disable iff (rst)
        eng_take |=> busy) else $error("program did not start");
    a_status_busy: assert property (@(posedge core_clk) disable iff (rst)
        (ce && sel && bsy_r && st_r == ST_IDLE && !sel_rise) |=> !so_r) else $error("busy not low");
    c_read: cover property (@(posedge core_clk) st_r == ST_READ);
    c_prog: cover property (@(posedge core_clk) eng_take);
    c_unlock: cover property (@(posedge core_clk) $rose(unl_r));
endmodule

/* rtl/sep_fifo.sv */
// Parameterised valid/ready FIFO
`timescale 1ns/1ps
module sep_fifo #(
    parameter int WIDTH = 27,
    parameter int DEPTH = 32
) (
    input  wire logic             core_clk,  // Clock
    input  wire logic             rst,       // Sync reset
    input  wire logic             ce,        // Clock enable
    input  wire logic             in_valid,  // Write offer
    output logic                  in_ready,  // Room left
    input  wire logic [WIDTH-1:0] in_data,   // Write word
    output logic                  out_valid, // Word present
    input  wire logic             out_ready, // Drain accepts
    output logic      [WIDTH-1:0] out_data   // Head word
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0]      cnt_r, cnt_nxt;
    logic             push, pop;

    // Pointer and count update
    always_comb begin
        push    = ce && in_valid && in_ready;
        pop     = ce && out_valid && out_ready;
        wp_nxt  = push ? wp_r + 1'b1 : wp_r;
        rp_nxt  = pop ? rp_r + 1'b1 : rp_r;
        cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
    always_ff @(posedge core_clk) begin
        if (rst) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end
    // Storage, no reset needed
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end
    assign in_ready  = cnt_r != (AW+1)'(DEPTH);
    assign out_valid = cnt_r != '0;
    assign out_data  = mem_r[rp_r];
endmodule

/* verification/sep_master.sv */
// Serial bus master model that drives the command port pins
`timescale 1ns/1ps
module sep_master (
    input  wire logic core_clk,     // Bench clock
    input  wire logic serial_out,   // Device data out
    output logic      chip_sel,     // Select pin
    output logic      serial_clock, // Serial clock pin
    output logic      serial_in     // Serial data pin
);
    // Each serial clock phase lasts ten core clocks, above the synchroniser floor
    localparam int HALF = 10;
    // Clock stands still between frames
    initial begin
        chip_sel = 1'b0;
        serial_clock = 1'b0;
        serial_in = 1'b0;
    end
    task automatic idle(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    // Select change, then a pause long enough to reset the device
    task automatic select(input logic v);
        @(negedge core_clk);
        chip_sel = v;
        idle(HALF);
    endtask
    // One bit out, output sampled at the end of the high phase
    task automatic bit_x(input logic b, output logic q);
        @(negedge core_clk);
        serial_in = b;
        idle(HALF);
        serial_clock = 1'b1;
        idle(HALF);
        q = serial_out;
        serial_clock = 1'b0;
        serial_in = ~b; // Data line no longer shows the old bit
    endtask
    // Whole command: zeros, start, opcode, address, data, read word
    task automatic frame(input int nz, input logic [1:0] op, input logic [8:0] a,
                         input int aw, input logic [15:0] d, input int dw, input int rw,
                         output logic [15:0] r, output logic dum);
        logic q;
        r = 16'h0000;
        dum = 1'b1;
        select(1'b1);
        repeat (nz) bit_x(1'b0, q);
        bit_x(1'b1, q);
        for (int i = 1; i >= 0; i--) bit_x(op[i], q);
        for (int i = aw - 1; i >= 0; i--) bit_x(a[i], q);
        dum = q;
        for (int i = dw - 1; i >= 0; i--) bit_x(d[i], q);
        for (int i = rw - 1; i >= 0; i--) begin
            bit_x(1'b0, q);
            r[i] = q;
        end
        select(1'b0);
    endtask
endmodule

/* verification/tb.sv */
// Self-checking bench for the command port against an array model
`timescale 1ns/1ps
module tb;
    import sep_pkg::*;
    logic core_clk, rst, ce, width_select, serial_out, serial_out_oe_n, busy;
    logic chip_sel, serial_clock, serial_in, q, dum, seen;
    logic [8:0]  a;
    logic [15:0] d, r;
    localparam int WP = 50; // Short program time for simulation
    int n_fail, cmp_count, cyc, seed, aw, dw, k, busy_cyc;
    int wmem[256];
    int bmem[512];
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    sep_core #(.T_WP_CYC(WP)) dut (.core_clk(core_clk), .rst(rst), .ce(ce),
        .chip_sel(chip_sel), .serial_clock(serial_clock), .serial_in(serial_in),
        .width_select(width_select), .serial_out(serial_out),
        .serial_out_oe_n(serial_out_oe_n), .busy(busy));
    sep_master m (.core_clk(core_clk), .serial_out(serial_out), .chip_sel(chip_sel),
        .serial_clock(serial_clock), .serial_in(serial_in));
    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Hang guard, far above the expected run length
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 90000) begin
            n_fail++;
            end_sim();
        end
    end
    // Enabled cycles spent busy; frozen cycles must not count
    always @(posedge core_clk) begin
        if (ce === 1'b1 && busy === 1'b1) busy_cyc++;
    end
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cmd(input logic [1:0] op, input logic [8:0] ad, input logic [15:0] dt,
                       input int nd);
        busy_cyc = 0;
        m.frame($random(seed) & 3, op, ad, aw, dt, nd, 0, r, dum);
    endtask
    // Control command: sub-command in the two top address bits, rest random
    task automatic ext(input logic [1:0] sub, input logic [15:0] dt);
        a = $random(seed);
        a[aw - 1] = sub[1];
        a[aw - 2] = sub[0];
        cmd(SEP_OP_EXT, a, dt, (sub == SEP_SUB_FILL) ? dw : 0);
    endtask
    task automatic rd(input logic [8:0] ad, input logic [15:0] e);
        m.frame($random(seed) & 3, SEP_OP_READ, ad, aw, 16'h0000, 0, dw, r, dum);
        chk("dummy", 16'h0000, {15'h0000, dum});
        chk("read", e, r);
    endtask
    // Program phase: either busy with status poll, or no busy at all
    task automatic prog(input logic exp_busy, input int nc = WP);
        if (exp_busy) begin
            for (k = 0; k < 20 && busy !== 1'b1; k++) @(negedge core_clk);
            chk("busy", 16'h0001, {15'h0000, busy});
            chk("oe_n idle", 16'h0001, {15'h0000, serial_out_oe_n});
            m.select(1'b1);
            chk("oe_n poll", 16'h0000, {15'h0000, serial_out_oe_n});
            chk("status busy", 16'h0000, {15'h0000, serial_out});
            // Random clock-enable gaps stretch the program in wall time only
            repeat (40) begin
                @(negedge core_clk);
                ce = $random(seed);
            end
            ce = 1'b1;
            for (k = 0; k < 800 && busy !== 1'b0; k++) @(negedge core_clk);
            chk("busy cycles", nc, busy_cyc);
            m.idle(6);
            chk("status ready", 16'h0001, {15'h0000, serial_out});
            m.bit_x(1'b1, q);
            m.idle(6);
            chk("oe_n cleared", 16'h0001, {15'h0000, serial_out_oe_n});
            m.select(1'b0);
        end else begin
            seen = 1'b0;
            repeat (70) begin
                @(negedge core_clk);
                seen = seen | busy;
            end
            chk("no busy", 16'h0000, {15'h0000, seen});
        end
    endtask
    initial begin
        seed = 32'hbdce;
        rst = 1'b1;
        ce = 1'b1;
        width_select = 1'b1;
        aw = SEP_ADDR_W16;
        dw = SEP_DATA_W16;
        repeat (12) @(negedge core_clk);
        rst = 1'b0;
        m.idle(4);
        chk("oe_n reset", 16'h0001, {15'h0000, serial_out_oe_n});
        // Deselected pin activity, including an unlock pattern, must do nothing
        for (int i = 0; i < 13; i++) begin
            width_select = $random(seed);
            m.bit_x(i < 3 || i > 4, q);
        end
        width_select = 1'b1;
        ext(SEP_SUB_CLEAR, 16'h0000);
        prog(1'b0);
        ext(SEP_SUB_UNLOCK, 16'h0000);
        ext(SEP_SUB_CLEAR, 16'h0000);
        prog(1'b1, SEP_ARRAY_BYTES);
        for (int i = 0; i < 256; i++) wmem[i] = 16'hffff;
        for (int i = 0; i < 512; i++) bmem[i] = 8'hff;
        rd($random(seed) & 8'hff, 16'hffff);
        d = $random(seed);
        ext(SEP_SUB_FILL, d);
        prog(1'b1, SEP_ARRAY_BYTES);
        for (int i = 0; i < 256; i++) wmem[i] = d;
        rd($random(seed) & 8'hff, d);
        // Random writes, each read back at once, with erases mixed in
        for (int i = 0; i < 6; i++) begin
            a = $random(seed) & 8'hff;
            d = $random(seed);
            if (i % 3 == 2) cmd(SEP_OP_ERASE, a, 16'h0000, 0);
            else cmd(SEP_OP_WRITE, a, d, dw);
            prog(1'b1);
            wmem[a] = (i % 3 == 2) ? 16'hffff : d;
            rd(a, wmem[a]);
        end
        // Mid-run reset relocks programming; the array keeps its words
        @(negedge core_clk);
        rst = 1'b1;
        repeat (3) @(negedge core_clk);
        rst = 1'b0;
        m.idle(4);
        chk("oe_n rerst", 16'h0001, {15'h0000, serial_out_oe_n});
        cmd(SEP_OP_WRITE, a, ~d, dw);
        prog(1'b0);
        rd(a, wmem[a]);
        // Select fall abandons a half-sent command
        m.select(1'b1);
        m.bit_x(1'b1, q);
        m.bit_x(1'b0, q);
        m.select(1'b0);
        rd(a, wmem[a]);
        ext(SEP_SUB_LOCK, 16'h0000);
        cmd(SEP_OP_WRITE, a, ~d, dw);
        prog(1'b0);
        cmd(SEP_OP_ERASE, a, 16'h0000, 0);
        prog(1'b0);
        rd(a, wmem[a]);
        // Narrow organization: 9-bit address, 8-bit word
        width_select = 1'b0;
        aw = SEP_ADDR_W8;
        dw = SEP_DATA_W8;
        ext(SEP_SUB_UNLOCK, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            a = $random(seed) & 9'h1ff;
            d = $random(seed) & 8'hff;
            if (i == 3) cmd(SEP_OP_ERASE, a, 16'h0000, 0);
            else cmd(SEP_OP_WRITE, a, d, dw);
            prog(1'b1);
            bmem[a] = (i == 3) ? 8'hff : d;
            rd(a, bmem[a]);
        end
        ext(SEP_SUB_LOCK, 16'h0000);
        end_sim();
    end
endmodule
